/* File: stc_torque_cutoff.sv */
`include "stc_defines.svh"

module stc_torque_cutoff
(
	input  wire logic             clk_sys_i,
	input  wire logic             resetn_i,
	input  wire logic             cutoff_channel_a_n_i,
	input  wire logic             cutoff_channel_b_n_i,
	input  wire logic             halt_n_i,
	input  wire logic             fault_reset_i,
	input  wire logic             enable_req_i,
	input  wire logic             power_up_auto_arm_i,
	output stc_pkg::stc_drive_t   drive_o,
	output stc_pkg::stc_error_t   error_o,
	output stc_pkg::stc_state_t   state_o
);
	import stc_pkg::*;

	function automatic logic chan_on(input logic lvl);
		chan_on = lvl;
	endfunction

	logic a_lvl;
	logic b_lvl;
	logic halt_lvl;
	logic a_on;
	logic b_on;
	logic both_on;
	logic both_off;

	stc_sync u_sync_a
	(
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.pin_i     (cutoff_channel_a_n_i),
		.level_o   (a_lvl)
	);
	stc_sync u_sync_b
	(
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.pin_i     (cutoff_channel_b_n_i),
		.level_o   (b_lvl)
	);
	stc_sync u_sync_h
	(
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.pin_i     (halt_n_i),
		.level_o   (halt_lvl)
	);

	assign a_on     = chan_on(a_lvl);
	assign b_on     = chan_on(b_lvl);
	assign both_on  = a_on & b_on;
	assign both_off = !a_on & !b_on;

	// history resets high: a request held through reset is not an edge
	logic en_prev_q;
	logic en_prev_d;
	logic en_rise;

	always_comb
	begin
		en_prev_d = enable_req_i;
		en_rise   = enable_req_i && !en_prev_q;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!resetn_i)
		begin
			en_prev_q <= 1'b1;
		end
		else
		begin
			en_prev_q <= en_prev_d;
		end
	end

	stc_state_t              state_q;
	stc_state_t              state_d;
	logic [`STC_SKEW_W-1:0]  skew_q;
	logic [`STC_SKEW_W-1:0]  skew_d;
	logic                    armed_q;
	logic                    armed_d;
	logic                    auto_seen_q;
	logic                    auto_seen_d;
	stc_drive_t              drive_q;
	stc_drive_t              drive_d;
	stc_error_t              err_q;
	stc_error_t              err_d;

	localparam logic [`STC_SKEW_W-1:0] SKEW_MAX = `STC_SKEW_W'(`STC_SKEW_CYCLES - 1);

	always_comb
	begin
		state_d     = state_q;
		skew_d      = skew_q;
		armed_d     = armed_q;
		auto_seen_d = 1'b1;
		err_d       = err_q;
		// strap caught once after release; arm only when auto-arm set
		if (!auto_seen_q && power_up_auto_arm_i && both_on)
		begin
			armed_d = 1'b1;
		end
		case (state_q)
			STC_RUN:
			begin
				if (both_off)
				begin
					state_d          = STC_STOPPED;
					err_d.stop_error = 1'b1;
					armed_d          = 1'b0;
				end
				else if (!both_on)
				begin
					state_d = STC_SKEW;
					skew_d  = '0;
					armed_d = 1'b0;
				end
			end
			STC_SKEW:
			begin
				// limit first: a skew of exactly 1s is already too late
				if (skew_q == SKEW_MAX)
				begin
					state_d          = STC_LOCKED;
					err_d.lock_error = 1'b1;
				end
				else if (both_off)
				begin
					state_d          = STC_STOPPED;
					err_d.stop_error = 1'b1;
				end
				else if (both_on)
				begin
					// channel came back alone
					state_d          = STC_LOCKED;
					err_d.lock_error = 1'b1;
				end
				else
				begin
					skew_d = skew_q + `STC_SKEW_W'(1);
				end
			end
			STC_STOPPED:
			begin
				if (!both_on && !both_off)
				begin
					state_d          = STC_LOCKED;
					err_d.lock_error = 1'b1;
				end
				else if (both_on && fault_reset_i)
				begin
					state_d          = STC_RUN;
					err_d.stop_error = 1'b0;
				end
			end
			STC_LOCKED:
			begin
				state_d = STC_LOCKED;
			end
			default:
			begin
				state_d          = STC_LOCKED;
				err_d.lock_error = 1'b1;
			end
		endcase
		if (state_d == STC_RUN && state_q == STC_RUN && en_rise && both_on)
		begin
			armed_d = 1'b1;
		end
		if (!enable_req_i)
		begin
			armed_d = 1'b0;
		end
		// stage follows state with no brake delay, no braking
		drive_d.power_stage_en = armed_d && (state_d == STC_RUN) && both_on;
		drive_d.brake_active   = 1'b0;
		drive_d.halt_decel     = !halt_lvl;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!resetn_i)
		begin
			state_q     <= STC_RUN;
			skew_q      <= '0;
			armed_q     <= 1'b0;
			auto_seen_q <= 1'b0;
			drive_q     <= '0;
			err_q       <= '0;
		end
		else
		begin
			state_q     <= state_d;
			skew_q      <= skew_d;
			armed_q     <= armed_d;
			auto_seen_q <= auto_seen_d;
			drive_q     <= drive_d;
			err_q       <= err_d;
		end
	end

	assign drive_o = drive_q;
	assign error_o = err_q;
	assign state_o = state_q;
endmodule

/* File: stc_defines.svh */
`ifndef STC_DEFINES_SVH
`define STC_DEFINES_SVH

`define STC_CLK_HZ          40000000
`define STC_SKEW_LIMIT_MS   1000
`define STC_SKEW_CYCLES     (`STC_CLK_HZ / 1000 * `STC_SKEW_LIMIT_MS)
`define STC_SKEW_W          26
`define STC_MS_CYCLES       (`STC_CLK_HZ / 1000)
`define STC_MS_W            16

`endif

/* File: stc_pkg.sv */
`include "stc_defines.svh"

package stc_pkg;

	typedef enum logic [1:0]
	{
		STC_RUN     = 2'b00,
		STC_SKEW    = 2'b01,
		STC_STOPPED = 2'b11,
		STC_LOCKED  = 2'b10
	} stc_state_t;

	typedef struct packed
	{
		logic power_stage_en;
		logic brake_active;
		logic halt_decel;
	} stc_drive_t;

	typedef struct packed
	{
		logic stop_error;
		logic lock_error;
	} stc_error_t;

endpackage

/* File: stc_sync.sv */
module stc_sync
(
	input  wire logic clk_sys_i,
	input  wire logic resetn_i,
	input  wire logic pin_i,
	output logic      level_o
);
	logic [2:0] sh_q;
	logic [2:0] sh_d;
	logic       lvl_q;
	logic       lvl_d;

	always_comb
	begin
		sh_d  = {sh_q[1:0], pin_i};
		lvl_d = lvl_q;
		if (sh_q[2] == sh_q[1])
		begin
			lvl_d = sh_q[1];
		end
	end

	// idle high: channel on after power-up sampling
	always_ff @(posedge clk_sys_i)
	begin
		if (!resetn_i)
		begin
			sh_q  <= 3'h7;
			lvl_q <= 1'b1;
		end
		else
		begin
			sh_q  <= sh_d;
			lvl_q <= lvl_d;
		end
	end

	assign level_o = lvl_q;
endmodule

/* File: stc_monitor.sv */
module stc_monitor
(
	input wire logic           clk_sys_i,
	input wire logic           resetn_i,
	input wire logic           cutoff_channel_a_n_i,
	input wire logic           cutoff_channel_b_n_i,
	input wire logic           halt_n_i,
	input wire logic           fault_reset_i,
	input wire logic           enable_req_i,
	input wire logic           power_up_auto_arm_i,
	input stc_pkg::stc_drive_t drive_o,
	input stc_pkg::stc_error_t error_o,
	input stc_pkg::stc_state_t state_o
);
	import stc_pkg::*;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	brake_zero_a: assert property (!drive_o.brake_active)
		else $error("brake driven");
	lock_sticky_a: assert property (error_o.lock_error |=> error_o.lock_error)
		else $error("lock error cleared");
	err_nodrive_a: assert property (error_o != 0 |-> !drive_o.power_stage_en)
		else $error("stage on with error");
	cut_fast_a: assert property (!(cutoff_channel_a_n_i && cutoff_channel_b_n_i)[*8]
		|-> !drive_o.power_stage_en) else $error("cutoff slow");
	stop_clear_a: assert property ($fell(error_o.stop_error) |-> $past(fault_reset_i))
		else $error("stop error cleared alone");
	halt_decel_a: assert property (!halt_n_i[*6] ##0 drive_o.power_stage_en
		|-> drive_o.halt_decel) else $error("no decel");
	restart_edge_a: assert property ($rose(drive_o.power_stage_en) && !power_up_auto_arm_i
		|-> $past(enable_req_i) && !$past(enable_req_i, 2)) else $error("enable without edge");
	lock_flag_a: assert property (state_o == STC_LOCKED |-> error_o.lock_error)
		else $error("lock without flag");
	stop_flag_a: assert property (state_o == STC_STOPPED |-> error_o.stop_error)
		else $error("stop without flag");
	cover property (error_o.stop_error);
	cover property (error_o.lock_error);
	cover property ($rose(drive_o.power_stage_en));
	cover property (state_o == STC_LOCKED);
endmodule

bind stc_torque_cutoff stc_monitor mon_u (.clk_sys_i, .resetn_i, .cutoff_channel_a_n_i,
	.cutoff_channel_b_n_i, .halt_n_i, .fault_reset_i, .enable_req_i, .power_up_auto_arm_i,
	.drive_o, .error_o, .state_o);

/* File: stc_relay.sv */
module stc_relay
(
	input  wire logic       clk_sys_i,
	input  wire logic [2:0] cmd_i,
	output logic      [2:0] pin_o = 3'h7
);
	timeunit 1ns;
	timeprecision 100ps;
	// contacts move only after an edge
	always @(posedge clk_sys_i)
		pin_o <= ~cmd_i;
endmodule

/* File: stc_testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import stc_pkg::*;
	logic       clk_sys_i = 0;
	logic       resetn_i = 0;
	logic       fault_reset_i = 0;
	logic       enable_req_i = 0;
	logic [2:0] cmd = 0;
	logic [2:0] pin;
	int         bad_count = 0;
	int         checked = 0;
	stc_drive_t drive_o;
	stc_error_t error_o;
	stc_state_t state_o;
	always #12.5 clk_sys_i = ~clk_sys_i;
	// auto-arm tied off: restart only by request
	stc_torque_cutoff dut_u (.clk_sys_i, .resetn_i, .cutoff_channel_a_n_i(pin[0]),
		.cutoff_channel_b_n_i(pin[1]), .halt_n_i(pin[2]), .fault_reset_i, .enable_req_i,
		.power_up_auto_arm_i(1'h0), .drive_o, .error_o, .state_o);
	stc_relay rly_u (.clk_sys_i, .cmd_i(cmd), .pin_o(pin));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("bad_count=%0d checked=%0d", bad_count, checked);
		if (bad_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#2;
	endtask
	task automatic wait_st(input stc_state_t s);
		for (int i = 0; i < 40 && state_o !== s; i++)
			step(1);
		if (state_o !== s)
		begin
			bad_count++;
			summarize();
		end
	endtask
	task automatic s_enable;
		enable_req_i = 0;
		step(1);
		enable_req_i = 1;
		step(3);
	endtask
	task automatic s_coord;
		s_enable();
		chk(drive_o, 8'h4);
		cmd = 3'h4;
		step(8);
		chk(drive_o, 8'h5);
		cmd = 3'h7;
		wait_st(STC_STOPPED);
		chk({error_o, drive_o.power_stage_en}, 8'h4);
		fault_reset_i = 1;
		step(2);
		chk(state_o, STC_STOPPED);
		fault_reset_i = 0;
		cmd = 3'h0;
		step(8);
		chk(drive_o.power_stage_en, 8'h0);
		fault_reset_i = 1;
		step(1);
		fault_reset_i = 0;
		wait_st(STC_RUN);
		chk(error_o, 8'h0);
		step(2);
		chk(drive_o.power_stage_en, 8'h0);
		s_enable();
		chk(drive_o, 8'h4);
	endtask
	task automatic s_lock;
		cmd = 3'h2;
		step(8);
		chk(drive_o, 8'h0);
		cmd = 3'h0;
		wait_st(STC_LOCKED);
		fault_reset_i = 1;
		step(3);
		fault_reset_i = 0;
		s_enable();
		chk({error_o, drive_o}, 8'h8);
		resetn_i = 0;
		step(5);
		resetn_i = 1;
		step(2);
		chk({error_o, drive_o, state_o}, 8'h0);
		s_enable();
		chk(drive_o, 8'h4);
	endtask
	initial
	begin
		step(5);
		resetn_i = 1;
		step(2);
		s_coord();
		s_lock();
		summarize();
	end
endmodule
